// file: logic/shs_core.sv
// shs_core.sv: streaming hash engine, padding and compression
// assumes a feeder on the usr modport of shs_if, one clock domain
`timescale 1ns/1ps
`include "shs_consts.svh"

module shs_core
  import shs_pkg::*;
(
  input  wire logic clock,   // system clock
  input  wire logic arst_n,  // async reset, active low
  input  wire logic enable,  // advance when high
  input  wire logic clr,     // sync clear
  shs_if.dev        lnk      // message and digest link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  shs_state_t             state_q, state_d;
  shs_phase_t             phase_q, phase_d;
  logic [3:0]             idx_q, idx_d;
  logic [6:0]             cnt_q, cnt_d;
  logic [63:0]            len_q, len_d;
  logic                   hi_q, hi_d;
  logic                   final_q, final_d;
  shs_word_t              w_q [0:15];
  shs_word_t              w_d [0:15];
  shs_word_t              hv_q [0:7];
  shs_word_t              hv_d [0:7];
  shs_word_t              v_q [0:7];
  shs_word_t              v_d [0:7];
  logic [`SHS_HASH_W-1:0] hash_q, hash_d;
  logic                   hvld_q, hvld_d;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic      word_en;
  shs_word_t word;
  shs_word_t t1;
  shs_word_t t2;
  shs_word_t wnew;
  logic      take;

  // ready decodes state and phase, gated by enable and clr, so a word is taken that cycle
  assign lnk.msg_ready  = enable & ~clr & (state_q == ST_FILL)
                        & (phase_q == PH_MSG);
  assign take           = lnk.msg_ready & lnk.msg_valid;
  assign lnk.hash_out   = hash_q;
  assign lnk.hash_valid = hvld_q;

  // round datapath on the working variables
  always_comb begin
    t1   = v_q[7] + big_s1(v_q[4]) + ((v_q[4] & v_q[5]) ^ (~v_q[4] & v_q[6]))
         + SHS_K[6'(cnt_q - 7'd1)] + w_q[0];
    t2   = big_s0(v_q[0])
         + ((v_q[0] & v_q[1]) ^ (v_q[0] & v_q[2]) ^ (v_q[1] & v_q[2]));
    wnew = sml_s1(w_q[14]) + w_q[9] + sml_s0(w_q[1]) + w_q[0];
  end

  // next-state: gathering, padding, compression, digest hold
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    idx_d   = idx_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    hi_d    = hi_q;
    final_d = final_q;
    w_d     = w_q;
    hv_d    = hv_q;
    v_d     = v_q;
    hash_d  = hash_q;
    hvld_d  = hvld_q;
    word_en = 1'b0;
    word    = '0;
    if (clr) begin
      state_d = ST_FILL;
      phase_d = PH_MSG;
      idx_d   = '0;
      cnt_d   = '0;
      len_d   = '0;
      hi_d    = 1'b0;
      final_d = 1'b0;
      hv_d    = SHS_IV;
      hvld_d  = 1'b0;
    end else if (enable) begin
      case (state_q)
        ST_FILL: begin
          case (phase_q)
            PH_MSG: begin
              if (take) begin
                word_en = 1'b1;
                if (lnk.msg_last) begin
                  // keep the valid leading bytes, mark the first free one
                  case (lnk.msg_size)
                    2'h1: word = {lnk.msg_in[31:24], 8'h80, 16'h0000};
                    2'h2: word = {lnk.msg_in[31:16], 8'h80, 8'h00};
                    2'h3: word = {lnk.msg_in[31:8], 8'h80};
                    default: word = lnk.msg_in;
                  endcase
                  len_d   = len_q + ((lnk.msg_size == 2'h0) ? 64'h20
                                    : {59'h0, lnk.msg_size, 3'h0});
                  phase_d = (lnk.msg_size == 2'h0) ? PH_P80 : PH_ZERO;
                end else begin
                  word  = lnk.msg_in;
                  len_d = len_q + 64'h20;
                end
              end
            end
            PH_P80: begin
              word_en = 1'b1;
              word    = `SHS_PAD_WORD;
              phase_d = PH_ZERO;
            end
            default: begin
              // zero fill, then the bit length in the last two words
              word_en = 1'b1;
              if (idx_q == `SHS_IDX_LEN_HI) begin
                word = len_q[63:32];
                hi_d = 1'b1;
              end else if (idx_q == `SHS_IDX_LAST && hi_q) begin
                word    = len_q[31:0];
                final_d = 1'b1;
              end
            end
          endcase
          if (word_en) begin
            w_d[idx_q] = word;
            idx_d      = idx_q + 4'h1;
            if (idx_q == `SHS_IDX_LAST) begin
              state_d = ST_COMP;
              cnt_d   = '0;
            end
          end
        end
        ST_COMP: begin
          cnt_d = cnt_q + 7'd1;
          if (cnt_q == 7'd0) begin
            v_d = hv_q;
          end else if (cnt_q <= 7'(`SHS_ROUNDS)) begin
            v_d[0] = t1 + t2;
            v_d[4] = v_q[3] + t1;
            for (int i = 1; i < 8; i++) begin
              if (i != 4) v_d[i] = v_q[i-1];
            end
            for (int i = 0; i < 15; i++) begin
              w_d[i] = w_q[i+1];
            end
            w_d[15] = wnew;
          end else begin
            for (int i = 0; i < 8; i++) begin
              hv_d[i] = hv_q[i] + v_q[i];
            end
            if (final_q) begin
              for (int i = 0; i < 8; i++) begin
                hash_d[255-32*i -: 32] = hv_q[i] + v_q[i];
              end
              hvld_d  = 1'b1;
              state_d = ST_DONE;
            end else begin
              state_d = ST_FILL;
            end
          end
        end
        ST_DONE: begin
          if (lnk.hash_ack) begin
            hvld_d  = 1'b0;
            state_d = ST_FILL;
            phase_d = PH_MSG;
            len_d   = '0;
            hi_d    = 1'b0;
            final_d = 1'b0;
            hv_d    = SHS_IV;
          end
        end
        default: state_d = ST_FILL;
      endcase
    end
  end

  // registers; async reset forces idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_FILL;
      phase_q <= PH_MSG;
      idx_q   <= '0;
      cnt_q   <= '0;
      len_q   <= '0;
      hi_q    <= 1'b0;
      final_q <= 1'b0;
      hv_q    <= SHS_IV;
      hash_q  <= '0;
      hvld_q  <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        w_q[i] <= '0;
      end
      for (int i = 0; i < 8; i++) begin
        v_q[i] <= '0;
      end
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      hi_q    <= hi_d;
      final_q <= final_d;
      hv_q    <= hv_d;
      hash_q  <= hash_d;
      hvld_q  <= hvld_d;
      w_q     <= w_d;
      v_q     <= v_d;
    end
  end

endmodule : shs_core

// file: logic/shs_consts.svh
// shs_consts.svh: constants of the streaming hash engine
// assumes inclusion by the package and both link ends
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH

// ---------------------------------------------------------------
// link widths and counts
// ---------------------------------------------------------------
`define SHS_WORD_W      32
`define SHS_SIZE_W      2
`define SHS_HASH_W      256
`define SHS_BLK_WORDS   16
`define SHS_ROUNDS      64
`define SHS_COMP_CYC    66
`define SHS_IDX_LEN_HI  4'hE
`define SHS_IDX_LAST    4'hF
`define SHS_PAD_WORD    32'h8000_0000

// ---------------------------------------------------------------
// initial chaining values, fixed at build time
// ---------------------------------------------------------------
`define SHS_IV0 32'h6a09e667
`define SHS_IV1 32'hbb67ae85
`define SHS_IV2 32'h3c6ef372
`define SHS_IV3 32'ha54ff53a
`define SHS_IV4 32'h510e527f
`define SHS_IV5 32'h9b05688c
`define SHS_IV6 32'h1f83d9ab
`define SHS_IV7 32'h5be0cd19

`endif

// file: logic/shs_pkg.sv
// shs_pkg.sv: types, round constants and round functions
// assumes shs_consts.svh on the include path
`include "shs_consts.svh"

package shs_pkg;

  typedef logic [`SHS_WORD_W-1:0] shs_word_t;
  typedef enum logic [1:0] {ST_FILL, ST_COMP, ST_DONE} shs_state_t;
  typedef enum logic [1:0] {PH_MSG, PH_P80, PH_ZERO} shs_phase_t;

  // ---------------------------------------------------------------
  // round constants
  // ---------------------------------------------------------------
  localparam shs_word_t SHS_K [0:63] = '{
    32'h428a2f98, 32'h71374491, 32'hb5c0fbcf, 32'he9b5dba5, 32'h3956c25b, 32'h59f111f1,
    32'h923f82a4, 32'hab1c5ed5, 32'hd807aa98, 32'h12835b01, 32'h243185be, 32'h550c7dc3,
    32'h72be5d74, 32'h80deb1fe, 32'h9bdc06a7, 32'hc19bf174, 32'he49b69c1, 32'hefbe4786,
    32'h0fc19dc6, 32'h240ca1cc, 32'h2de92c6f, 32'h4a7484aa, 32'h5cb0a9dc, 32'h76f988da,
    32'h983e5152, 32'ha831c66d, 32'hb00327c8, 32'hbf597fc7, 32'hc6e00bf3, 32'hd5a79147,
    32'h06ca6351, 32'h14292967, 32'h27b70a85, 32'h2e1b2138, 32'h4d2c6dfc, 32'h53380d13,
    32'h650a7354, 32'h766a0abb, 32'h81c2c92e, 32'h92722c85, 32'ha2bfe8a1, 32'ha81a664b,
    32'hc24b8b70, 32'hc76c51a3, 32'hd192e819, 32'hd6990624, 32'hf40e3585, 32'h106aa070,
    32'h19a4c116, 32'h1e376c08, 32'h2748774c, 32'h34b0bcb5, 32'h391c0cb3, 32'h4ed8aa4a,
    32'h5b9cca4f, 32'h682e6ff3, 32'h748f82ee, 32'h78a5636f, 32'h84c87814, 32'h8cc70208,
    32'h90befffa, 32'ha4506ceb, 32'hbef9a3f7, 32'hc67178f2};

  localparam shs_word_t SHS_IV [0:7] = '{`SHS_IV0, `SHS_IV1, `SHS_IV2, `SHS_IV3,
                                         `SHS_IV4, `SHS_IV5, `SHS_IV6, `SHS_IV7};

  // ---------------------------------------------------------------
  // round functions
  // ---------------------------------------------------------------
  function automatic shs_word_t rotr(shs_word_t x, int n);
    rotr = (x >> n) | (x << (32 - n));
  endfunction : rotr

  function automatic shs_word_t big_s0(shs_word_t x);
    big_s0 = rotr(x, 2) ^ rotr(x, 13) ^ rotr(x, 22);
  endfunction : big_s0

  function automatic shs_word_t big_s1(shs_word_t x);
    big_s1 = rotr(x, 6) ^ rotr(x, 11) ^ rotr(x, 25);
  endfunction : big_s1

  function automatic shs_word_t sml_s0(shs_word_t x);
    sml_s0 = rotr(x, 7) ^ rotr(x, 18) ^ (x >> 3);
  endfunction : sml_s0

  function automatic shs_word_t sml_s1(shs_word_t x);
    sml_s1 = rotr(x, 17) ^ rotr(x, 19) ^ (x >> 10);
  endfunction : sml_s1

endpackage : shs_pkg

// file: logic/shs_if.sv
// shs_if.sv: message and digest link between feeder and engine
// assumes both ends share the clock of the testbench
`timescale 1ns/1ps
`include "shs_consts.svh"

interface shs_if;
  logic [`SHS_WORD_W-1:0] msg_in;     // message word
  logic                   msg_valid;  // word qualifier
  logic                   msg_ready;  // engine can take word
  logic                   msg_last;   // final word marker
  logic [`SHS_SIZE_W-1:0] msg_size;   // valid bytes, 0 = four
  logic [`SHS_HASH_W-1:0] hash_out;   // digest
  logic                   hash_valid; // digest qualifier
  logic                   hash_ack;   // digest taken

  modport dev (input msg_in, msg_valid, msg_last, msg_size, hash_ack,
               output msg_ready, hash_out, hash_valid);
  modport usr (output msg_in, msg_valid, msg_last, msg_size, hash_ack,
               input msg_ready, hash_out, hash_valid);
endinterface : shs_if

// file: logic/shs_feed.sv
// shs_feed.sv: user end of the link, word feeder and digest taker
// assumes user logic that holds its word until usr_ready
`timescale 1ns/1ps
`include "shs_consts.svh"

module shs_feed
  import shs_pkg::*;
(
  input  wire logic                   clock,      // system clock
  input  wire logic                   arst_n,     // async reset, active low
  input  wire logic [`SHS_WORD_W-1:0] usr_data,   // message word
  input  wire logic                   usr_valid,  // word offered
  input  wire logic                   usr_last,   // final word of message
  input  wire logic [`SHS_SIZE_W-1:0] usr_size,   // bytes in final word
  output logic                        usr_ready,  // word taken
  input  wire logic                   usr_take,   // user can take a digest
  output logic [`SHS_HASH_W-1:0]      usr_digest, // captured digest
  output logic                        usr_dvalid, // one-cycle digest pulse while the engine is enabled or cleared
  shs_if.usr                          lnk         // message and digest link
);

  logic [`SHS_WORD_W-1:0] wd_q, wd_d;
  logic                   vl_q, vl_d;
  logic                   ls_q, ls_d;
  logic [`SHS_SIZE_W-1:0] sz_q, sz_d;
  logic [`SHS_HASH_W-1:0] dg_q, dg_d;
  logic                   dv_q, dv_d;

  // word holds on the link until the engine takes it
  assign lnk.msg_in    = wd_q;
  assign lnk.msg_valid = vl_q;
  assign lnk.msg_last  = ls_q;
  assign lnk.msg_size  = sz_q;
  assign usr_ready     = ~vl_q | lnk.msg_ready;
  // ack lasts one cycle while the engine is enabled or cleared, as it then drops valid after it
  assign lnk.hash_ack  = lnk.hash_valid & usr_take;
  assign usr_digest    = dg_q;
  assign usr_dvalid    = dv_q;

  // next values of the holding stage and digest capture
  always_comb begin
    wd_d = wd_q;
    vl_d = vl_q;
    ls_d = ls_q;
    sz_d = sz_q;
    dg_d = dg_q;
    dv_d = 1'b0;
    if (usr_ready) begin
      vl_d = usr_valid;
      if (usr_valid) begin
        wd_d = usr_data;
        ls_d = usr_last;
        sz_d = usr_size;
      end
    end
    if (lnk.hash_ack) begin
      dg_d = lnk.hash_out;
      dv_d = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wd_q <= '0;
      vl_q <= 1'b0;
      ls_q <= 1'b0;
      sz_q <= '0;
      dg_q <= '0;
      dv_q <= 1'b0;
    end else begin
      wd_q <= wd_d;
      vl_q <= vl_d;
      ls_q <= ls_d;
      sz_q <= sz_d;
      dg_q <= dg_d;
      dv_q <= dv_d;
    end
  end

endmodule : shs_feed

// file: bench/shs_link_monitor.sv
// shs_link_monitor.sv: timing checks on the message and digest link
// assumes one clock domain and instantiation beside the link in tb
`timescale 1ns/1ps
`include "shs_consts.svh"

module shs_link_monitor (
  input wire logic                   clock,      // system clock
  input wire logic                   arst_n,     // async reset, active low
  input wire logic                   enable,     // engine enable
  input wire logic                   clr,        // engine sync clear
  input wire logic [`SHS_WORD_W-1:0] msg_in,     // message word
  input wire logic                   msg_valid,  // word qualifier
  input wire logic                   msg_ready,  // engine takes word
  input wire logic                   msg_last,   // final word marker
  input wire logic [`SHS_SIZE_W-1:0] msg_size,   // bytes in final word
  input wire logic [`SHS_HASH_W-1:0] hash_out,   // digest
  input wire logic                   hash_valid, // digest qualifier
  input wire logic                   hash_ack    // digest taken
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // word position within the current block
  // ---------------------------------------------------------------
  logic       take;
  logic [3:0] wcnt_q;
  logic [3:0] wcnt_d;
  assign take = msg_valid & msg_ready;

  // next position: wraps at 16, restarts after final word
  always_comb begin
    wcnt_d = wcnt_q;
    if (clr) wcnt_d = 4'h0;
    else if (take) wcnt_d = msg_last ? 4'h0 : wcnt_q + 4'h1;
  end

  // position register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) wcnt_q <= 4'h0;
    else wcnt_q <= wcnt_d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_block_stall: assert property (take && wcnt_q == 4'hf |=> !msg_ready [*8])
    else $error("ready stayed up after a full block");
  chk_comp_cycles: assert property (take && wcnt_q == 4'hf && !msg_last
      |-> ##66 !msg_ready ##1 msg_ready)
    else $error("block compression not 66 cycles");
  chk_final_latency: assert property (take && msg_last && wcnt_q == 4'h0
      |-> ##81 !hash_valid ##1 hash_valid)
    else $error("digest of one-word message not at cycle 82");
  chk_busy_refuse: assert property (hash_valid |-> !msg_ready)
    else $error("ready while digest pending");
  chk_digest_hold: assert property (hash_valid && !hash_ack && !clr
      |=> hash_valid && $stable(hash_out))
    else $error("digest changed before ack");
  chk_ack_clears: assert property (hash_valid && hash_ack && enable && !clr
      |=> !hash_valid)
    else $error("digest valid kept after ack");
  chk_ready_after_ack: assert property (hash_valid && hash_ack && enable && !clr
      |=> msg_ready || !enable || clr)
    else $error("ready not back after ack");
  chk_clear_idle: assert property (clr |=> !hash_valid)
    else $error("digest valid after clear");
  chk_ready_gated: assert property (clr || !enable |-> !msg_ready)
    else $error("ready while cleared or disabled");
  chk_enable_hold: assert property (!enable && !clr
      |=> $stable(hash_valid) && $stable(hash_out))
    else $error("digest moved while disabled");
endmodule : shs_link_monitor

// file: bench/tb.sv
// tb.sv: engine and feeder joined by the link, known digests checked
// assumes shs_consts.svh on the include path
`timescale 1ns/1ps
`include "shs_consts.svh"

module tb;
  import shs_pkg::*;
  localparam time DLY = 1ns;
  localparam logic [255:0] D_A   = 256'hca978112ca1bbdcafac231b39a23dc4da786eff8147c4e72b9807785afee48bb;
  localparam logic [255:0] D_AB  = 256'hfb8e20fc2e4c3f248c60c39bd652f3c1347298bb977b8b4d5903b85055620603;
  localparam logic [255:0] D_ABC = 256'hba7816bf8f01cfea414140de5dae2223b00361a396177a9cb410ff61f20015ad;
  localparam logic [255:0] D_56  = 256'h248d6a61d20638b8e5c026930c3e6039a33ce45964ff2167f6ecedd419db06c1;
  localparam logic [255:0] D_112 = 256'hcf5b16a778af8380036ce59e7b0492370b249b11e8f07a51afac45037afee9d1;

  logic                   clock;      // system clock
  logic                   arst_n;     // async reset
  logic                   enable;     // engine enable
  logic                   clr;        // engine clear
  logic [`SHS_WORD_W-1:0] usr_data;   // offered word
  logic                   usr_valid;  // word offered
  logic                   usr_last;   // final word
  logic [`SHS_SIZE_W-1:0] usr_size;   // bytes in final word
  logic                   usr_ready;  // word taken
  logic                   usr_take;   // digest wanted
  logic [`SHS_HASH_W-1:0] usr_digest; // captured digest
  logic                   usr_dvalid; // digest pulse
  int                     error_cnt;
  int                     samples_checked;
  string                  s;

  shs_if shs_if_inst ();
  shs_core shs_core_inst (.clock(clock), .arst_n(arst_n), .enable(enable), .clr(clr),
                          .lnk(shs_if_inst));
  shs_feed shs_feed_inst (.clock(clock), .arst_n(arst_n), .usr_data(usr_data),
    .usr_valid(usr_valid), .usr_last(usr_last), .usr_size(usr_size), .usr_ready(usr_ready),
    .usr_take(usr_take), .usr_digest(usr_digest), .usr_dvalid(usr_dvalid),
    .lnk(shs_if_inst));
  shs_link_monitor shs_link_monitor_inst (.clock(clock), .arst_n(arst_n), .enable(enable),
    .clr(clr), .msg_in(shs_if_inst.msg_in), .msg_valid(shs_if_inst.msg_valid),
    .msg_ready(shs_if_inst.msg_ready), .msg_last(shs_if_inst.msg_last),
    .msg_size(shs_if_inst.msg_size), .hash_out(shs_if_inst.hash_out),
    .hash_valid(shs_if_inst.hash_valid), .hash_ack(shs_if_inst.hash_ack));

  // clock generator, 10 ns period
  always #5 clock = ~clock;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  // offer one word and hold it until the feeder takes it
  task automatic send_word(input logic [31:0] d, input logic l, input logic [1:0] sz);
    int n;
    usr_data = d;
    usr_valid = 1'b1;
    usr_last = l;
    usr_size = sz;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (usr_ready !== 1'b1 && n < 200);
    if (n >= 200) check(256'h0, 256'h1, "word never taken");
    @(posedge clock);
    #DLY;
  endtask : send_word

  // feed a byte string, stall the digest, then take and compare it
  task automatic hash_msg(input string m, input logic [255:0] exp);
    logic [31:0] w;
    int          i;
    int          j;
    int          n;
    for (i = 0; i < m.len(); i += 4) begin
      w = 32'ha5a5a5a5; // filler beyond the byte count
      for (j = 0; j < 4 && i + j < m.len(); j++) w[31-8*j -: 8] = m[i+j];
      send_word(w, (i + 4 >= m.len()), 2'(m.len() - i));
    end
    usr_valid = 1'b0;
    usr_last = 1'b0;
    n = 0;
    while (shs_if_inst.hash_valid !== 1'b1 && n < 300) begin
      @(posedge clock);
      #DLY;
      n++;
    end
    if (n >= 300) check(256'h0, 256'h1, "digest never valid");
    repeat (3) begin
      check(256'(shs_if_inst.msg_ready), 256'h0, "ready during digest hold");
      @(posedge clock);
      #DLY;
    end
    enable = 1'b0;
    repeat (3) @(posedge clock);
    #DLY;
    check(256'(shs_if_inst.hash_valid), 256'h1, "digest lost while stalled");
    enable = 1'b1;
    usr_take = 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      #DLY;
      n++;
    end while (usr_dvalid !== 1'b1 && n < 10);
    usr_take = 1'b0;
    check(256'(usr_dvalid), 256'h1, "digest pulse missing");
    check(usr_digest, exp, "digest value");
    check(256'(shs_if_inst.msg_ready), 256'h1, "ready after ack");
  endtask : hash_msg

  // sliding-letter message: 14 groups of len letters
  task automatic build(input int len, output string m);
    m = "";
    for (int i = 0; i < 14; i++) begin
      for (int j = 0; j < len; j++) m = $sformatf("%s%c", m, 8'h61 + i + j);
    end
  endtask : build

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    enable = 1'b1;
    clr = 1'b0;
    usr_data = '0;
    usr_valid = 1'b0;
    usr_last = 1'b0;
    usr_size = '0;
    usr_take = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    #DLY;
    arst_n = 1'b1;
    @(posedge clock);
    #DLY;
    check(256'(shs_if_inst.hash_valid), 256'h0, "valid after reset");
    check(256'(shs_if_inst.msg_ready), 256'h1, "ready after reset");
    hash_msg("a", D_A);
    hash_msg("ab", D_AB);
    hash_msg("abc", D_ABC);
    build(4, s);
    hash_msg(s, D_56);
    build(8, s);
    hash_msg(s, D_112);
    // partial block dropped by the sync clear
    repeat (5) send_word(32'h01234567, 1'b0, 2'h0);
    usr_valid = 1'b0;
    repeat (3) @(posedge clock);
    #DLY;
    clr = 1'b1;
    #DLY;
    check(256'(shs_if_inst.msg_ready), 256'h0, "ready during clear");
    @(posedge clock);
    #DLY;
    clr = 1'b0;
    hash_msg("abc", D_ABC);
    // partial block dropped by the async reset
    repeat (3) send_word(32'h89abcdef, 1'b0, 2'h0);
    usr_valid = 1'b0;
    repeat (3) @(posedge clock);
    #DLY;
    arst_n = 1'b0;
    #DLY;
    check(256'(shs_if_inst.hash_valid), 256'h0, "valid in reset");
    check(shs_if_inst.hash_out, 256'h0, "digest kept in reset");
    @(posedge clock);
    #DLY;
    arst_n = 1'b1;
    hash_msg("ab", D_AB);
    give_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
endmodule : tb
